// [logic/cir_pkg.sv]
/*
  Shared constants and types for the processor interrupt and reset control block.
  Assumes a single 200 MHz clock domain and a synchronous active-high reset.
*/
`default_nettype none

package cir_pkg;

  // Positions of the pins that pass through the input synchroniser.
  localparam int SYNC_W = 5;
  localparam int SY_NMI = 0;
  localparam int SY_MASKABLE_IRQ_REQ = 1;
  localparam int SY_TEST_N = 2;
  localparam int SY_HOLD = 3;
  localparam int SY_MAXM = 4;

  // Start-up and arming counts, in processor clocks.
  localparam logic [2:0] INIT_CLOCKS = 3'h7;
  localparam logic [1:0] NMI_ARM_CLOCKS = 2'h2;

  // Address constants.
  localparam logic [19:0] RESET_VECTOR = 20'hFFFF0;
  localparam logic [3:0] IO_UPPER_ZERO = 4'h0;
  localparam logic [7:0] IO_PAGE_ZERO = 8'h00;
  localparam logic [7:0] NMI_TYPE = 8'h02;
  localparam logic [1:0] VEC_ENTRY_LSB = 2'h0;
  localparam int VEC_W = 10;

  // Encodings of the three cycle status lines.
  localparam logic [2:0] CS_IRQ_ACK_STROBE = 3'h0;
  localparam logic [2:0] CS_IOR = 3'h1;
  localparam logic [2:0] CS_IOW = 3'h2;
  localparam logic [2:0] CS_HALT = 3'h3;
  localparam logic [2:0] CS_FETCH = 3'h4;
  localparam logic [2:0] CS_PASSIVE = 3'h7;

  // Minimum mode halt indication on select, direction and status-zero.
  localparam logic HALT_IO_MEM = 1'h1;
  localparam logic HALT_DIR = 1'h1;
  localparam logic HALT_SS0 = 1'h1;

  // Bus states of one acknowledge cycle.
  localparam logic [1:0] BS_T1 = 2'h0;
  localparam logic [1:0] BS_T2 = 2'h1;
  localparam logic [1:0] BS_T3 = 2'h2;
  localparam logic [1:0] BS_T4 = 2'h3;

  typedef enum logic [2:0] {ST_RESET, ST_INIT, ST_RUN, ST_ACK, ST_HALT, ST_HOLD} cir_state_type;

endpackage

`default_nettype wire

// [logic/cir_pin_if.sv]
/*
  Carrier between the control block and its pin synchroniser.
  Assumes both ends run on the same processor clock.
*/
`default_nettype none

interface cir_pin_if;
  import cir_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

`default_nettype wire

// [logic/cir_pin_sync.sv]
/*
  Three-stage synchroniser with agreement filter for asynchronous pins.
  Assumes raw inputs may change at any time relative to clk.
*/
`default_nettype none

module cir_pin_sync (
  input wire logic clk,
  input wire logic srst,
  cir_pin_if.sync pins
);
  import cir_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] clean;
  } cir_sync_state_type;

  cir_sync_state_type q;
  cir_sync_state_type next_q;

  // A bit changes only once stages two and three agree, so one late stage cannot glitch it.
  always_comb begin
    next_q = q;
    next_q.s1 = pins.raw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.clean = (q.s2 & q.s3) | (q.clean & (q.s2 ^ q.s3));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pins.clean = q.clean;

endmodule // cir_pin_sync

`default_nettype wire

// [logic/cir_ctrl.sv]
/*
  Processor reset, interrupt, halt, lock, test-wait and I/O address control.
  Assumes the execution core supplies one-cycle event pulses on clk and
  that the asynchronous pins are filtered by the pin synchroniser below.
*/
`default_nettype none

// Function
// - I/O cycles drive the port on the low sixteen lines, upper four zero.
// - Direct I/O reaches 256 ports; pointer-register I/O reaches all 64k.
// - Reset stops everything and keeps the block dormant while high.
// - About seven start-up clocks after reset, then fetch from the top vector.
// - Non-maskable edges before the second clock after reset are ignored.
// - Type byte times four forms a vector address below 400 hex.
// - Non-maskable rising edge raises type 2, ahead of the maskable request.
// - Non-maskable edge is latched, serviced at a boundary, re-armed on service.
// - Maskable request is a sampled level, ignored while interrupts are disabled.
// - Every response pushes flags and clears the interrupt enable.
// - Two back-to-back acknowledge cycles, type in the second; no hold grant meanwhile.
// - Max mode locks from second state of first acknowledge to that of second.
// - Halt shows status; minimum mode latch strobe comes one clock late.
// - A hold during halt keeps halt and reissues the indication afterwards.
// - Only an accepted interrupt or reset leaves halt.
// - Lock prefix locks next clock until instruction end; held requests granted after.
// - Test wait repeats until test goes low; no bus cycles once queue full.
// - Hold during test wait floats outputs; interrupts processed after regaining bus.
module cir_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic max_mode_strap,
  input wire logic nmi_pin,
  input wire logic maskable_irq_req,
  input wire logic test_n,
  input wire logic hold_req,
  input wire logic instr_end,
  input wire logic halt_exec,
  input wire logic lock_prefix,
  input wire logic lock_end,
  input wire logic wait_exec,
  input wire logic queue_full,
  input wire logic if_set,
  input wire logic if_clear,
  input wire logic flags_restore,
  input wire logic restored_if,
  input wire logic io_req,
  input wire logic io_write,
  input wire logic io_direct,
  input wire logic [7:0] io_port,
  input wire logic [15:0] io_pointer_reg,
  input wire logic [7:0] type_byte,
  output logic core_run,
  output logic fetch_start,
  output logic [19:0] addr,
  output logic ale,
  output logic irq_ack_strobe_n,
  output logic lock_n,
  output logic [2:0] cycle_status,
  output logic io_mem,
  output logic xfer_direction,
  output logic status_zero_min,
  output logic service_start,
  output logic [cir_pkg::VEC_W-1:0] vector_addr,
  output logic flags_push,
  output logic if_flag,
  output logic hold_grant,
  output logic halted,
  output logic wait_done,
  output logic bus_quiet
);
  import cir_pkg::*;

  typedef struct packed {
    cir_state_type st;
    logic [2:0] cnt;
    logic [1:0] arm_cnt;
    logic [1:0] bst;
    logic ack_second;
    logic nmi_prev;
    logic nmi_pend;
    logic pfx_lock;
    logic ack_lock;
    logic hold_rec;
    logic halt_ret;
    logic halt_new;
    logic ale_due;
    logic waiting;
    logic resume;
    logic core_run;
    logic fetch_start;
    logic [19:0] addr;
    logic ale;
    logic irq_ack_strobe_n;
    logic lock_n;
    logic [2:0] cycle_status;
    logic io_mem;
    logic xfer_direction;
    logic status_zero_min;
    logic service_start;
    logic [VEC_W-1:0] vector_addr;
    logic flags_push;
    logic if_flag;
    logic hold_grant;
    logic halted;
    logic wait_done;
    logic bus_quiet;
  } cir_ctrl_state_type;

  cir_ctrl_state_type q;
  cir_ctrl_state_type next_q;
  logic max_mode;
  logic maskable_irq_req_s;
  logic nmi_rise;
  logic irq_ok;
  logic boundary;
  logic grant_now;
  logic io_take;

  cir_pin_if pin_bus ();

  // Every pin from outside the clock domain goes through the filtered synchroniser.
  assign pin_bus.raw = {max_mode_strap, hold_req, test_n, maskable_irq_req, nmi_pin};

  cir_pin_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pins(pin_bus.sync)
  );

  // Derived conditions shared by several states.
  assign max_mode = pin_bus.clean[SY_MAXM];
  assign maskable_irq_req_s = pin_bus.clean[SY_MASKABLE_IRQ_REQ];
  assign nmi_rise = pin_bus.clean[SY_NMI] & ~q.nmi_prev;
  assign irq_ok = maskable_irq_req_s & q.if_flag;
  assign boundary = instr_end | q.waiting | q.resume;
  assign grant_now = (pin_bus.clean[SY_HOLD] | q.hold_rec) & ~q.pfx_lock & ~q.ack_lock;

  // Next-state logic; pulses default low and the state case overrides the software flag writes.
  always_comb begin
    next_q = q;
    io_take = 1'b0;
    next_q.fetch_start = 1'b0;
    next_q.ale = 1'b0;
    next_q.service_start = 1'b0;
    next_q.flags_push = 1'b0;
    next_q.wait_done = 1'b0;
    next_q.resume = 1'b0;
    next_q.nmi_prev = pin_bus.clean[SY_NMI];
    if (q.arm_cnt != NMI_ARM_CLOCKS) begin
      next_q.arm_cnt = q.arm_cnt + 2'h1;
    end
    if (if_set) begin
      next_q.if_flag = 1'b1;
    end
    if (if_clear) begin
      next_q.if_flag = 1'b0;
    end
    if (flags_restore) begin
      next_q.if_flag = restored_if;
    end
    if (lock_prefix) begin
      next_q.pfx_lock = 1'b1;
    end else if (lock_end) begin
      next_q.pfx_lock = 1'b0;
    end
    if (pin_bus.clean[SY_HOLD] && q.pfx_lock) begin
      next_q.hold_rec = 1'b1;
    end
    if (wait_exec && q.core_run) begin
      next_q.waiting = 1'b1;
    end
    case (q.st)
      ST_RESET: begin
        next_q.st = ST_INIT;
        next_q.cnt = 3'h0;
      end
      ST_INIT: begin
        if (q.cnt == INIT_CLOCKS - 3'h1) begin
          next_q.st = ST_RUN;
          next_q.core_run = 1'b1;
          next_q.fetch_start = 1'b1;
          next_q.addr = RESET_VECTOR;
          next_q.cycle_status = CS_FETCH;
          next_q.ale = 1'b1;
        end else begin
          next_q.cnt = q.cnt + 3'h1;
        end
      end
      ST_RUN: begin
        next_q.cycle_status = CS_PASSIVE;
        next_q.io_mem = 1'b0;
        if (q.waiting && !pin_bus.clean[SY_TEST_N]) begin
          next_q.waiting = 1'b0;
          next_q.wait_done = 1'b1;
        end
        if (grant_now) begin
          next_q.st = ST_HOLD;
          next_q.hold_grant = 1'b1;
        end else if (boundary && q.nmi_pend) begin
          next_q.nmi_pend = 1'b0;
          next_q.service_start = 1'b1;
          next_q.vector_addr = {NMI_TYPE, VEC_ENTRY_LSB};
          next_q.flags_push = 1'b1;
          next_q.if_flag = 1'b0;
          next_q.waiting = 1'b0;
        end else if (boundary && irq_ok) begin
          next_q.st = ST_ACK;
          next_q.bst = BS_T1;
          next_q.ack_second = 1'b0;
          next_q.flags_push = 1'b1;
          next_q.if_flag = 1'b0;
          next_q.waiting = 1'b0;
          next_q.ale = ~max_mode;
          next_q.cycle_status = CS_IRQ_ACK_STROBE;
          next_q.xfer_direction = 1'b0;
          next_q.status_zero_min = 1'b0;
        end else if (halt_exec) begin
          next_q.st = ST_HALT;
          next_q.halt_new = 1'b1;
        end else if (io_req) begin
          io_take = 1'b1;
        end
      end
      ST_ACK: begin
        next_q.bst = q.bst + 2'h1;
        if (q.bst == BS_T4) begin
          if (!q.ack_second) begin
            next_q.ack_second = 1'b1;
            next_q.ale = ~max_mode;
          end else begin
            next_q.st = ST_RUN;
            next_q.ack_second = 1'b0;
            next_q.service_start = 1'b1;
            next_q.vector_addr = {type_byte, VEC_ENTRY_LSB};
            next_q.cycle_status = CS_PASSIVE;
          end
        end
        if (max_mode && next_q.bst == BS_T2) begin
          next_q.ack_lock = ~q.ack_second;
        end
      end
      ST_HALT: begin
        if (q.halt_new) begin
          next_q.halt_new = 1'b0;
          next_q.halted = 1'b1;
          next_q.ale_due = ~max_mode;
          if (max_mode) begin
            next_q.cycle_status = CS_HALT;
          end else begin
            next_q.io_mem = HALT_IO_MEM;
            next_q.xfer_direction = HALT_DIR;
            next_q.status_zero_min = HALT_SS0;
          end
        end else begin
          next_q.ale = q.ale_due;
          next_q.ale_due = 1'b0;
          if (q.nmi_pend || irq_ok) begin
            next_q.st = ST_RUN;
            next_q.halted = 1'b0;
            next_q.resume = 1'b1;
            next_q.cycle_status = CS_PASSIVE;
            next_q.io_mem = 1'b0;
          end else if (grant_now) begin
            next_q.st = ST_HOLD;
            next_q.halt_ret = 1'b1;
            next_q.hold_grant = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (!pin_bus.clean[SY_HOLD]) begin
          next_q.hold_grant = 1'b0;
          next_q.hold_rec = 1'b0;
          next_q.halt_ret = 1'b0;
          next_q.halt_new = q.halt_ret;
          next_q.st = q.halt_ret ? ST_HALT : ST_RUN;
        end
      end
      default: begin
        next_q.st = ST_RESET;
      end
    endcase
    // The I/O address keeps memory format with the top nibble forced to zero.
    if (io_take) begin
      next_q.addr = {IO_UPPER_ZERO, io_direct ? {IO_PAGE_ZERO, io_port} : io_pointer_reg};
      next_q.cycle_status = io_write ? CS_IOW : CS_IOR;
      next_q.io_mem = 1'b1;
      next_q.xfer_direction = io_write;
      next_q.status_zero_min = ~io_write;
      next_q.ale = 1'b1;
    end
    // A new edge in the service cycle is kept: the set is applied after the clear.
    if (nmi_rise && q.arm_cnt == NMI_ARM_CLOCKS) begin
      next_q.nmi_pend = 1'b1;
    end
    next_q.irq_ack_strobe_n = !(next_q.st == ST_ACK
                                && (next_q.bst == BS_T2 || next_q.bst == BS_T3));
    next_q.lock_n = ~(next_q.pfx_lock | next_q.ack_lock);
    next_q.bus_quiet = next_q.waiting & queue_full;
  end

  // Synchronous reset holds the block dormant; release starts the start-up count.
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.irq_ack_strobe_n <= 1'b1;
      q.lock_n <= 1'b1;
      q.cycle_status <= CS_PASSIVE;
    end else begin
      q <= next_q;
    end
  end

  assign core_run = q.core_run;
  assign fetch_start = q.fetch_start;
  assign addr = q.addr;
  assign ale = q.ale;
  assign irq_ack_strobe_n = q.irq_ack_strobe_n;
  assign lock_n = q.lock_n;
  assign cycle_status = q.cycle_status;
  assign io_mem = q.io_mem;
  assign xfer_direction = q.xfer_direction;
  assign status_zero_min = q.status_zero_min;
  assign service_start = q.service_start;
  assign vector_addr = q.vector_addr;
  assign flags_push = q.flags_push;
  assign if_flag = q.if_flag;
  assign hold_grant = q.hold_grant;
  assign halted = q.halted;
  assign wait_done = q.wait_done;
  assign bus_quiet = q.bus_quiet;

  // I/O cycles never carry a non-zero top nibble.
  property p_io_upper;
    @(posedge clk) disable iff (srst) io_take |=> addr[19:16] == IO_UPPER_ZERO;
  endproperty
  a_io_upper: assert property (p_io_upper) else $error("io upper nibble not zero");

  property p_io_direct;
    @(posedge clk) disable iff (srst) (io_take && io_direct) |=> addr[15:8] == IO_PAGE_ZERO;
  endproperty
  a_io_direct: assert property (p_io_direct) else $error("direct io left page zero");

  property p_startup;
    @(posedge clk) disable iff (srst) $fell(srst) |-> !core_run [*8] ##1 (fetch_start && addr == RESET_VECTOR);
  endproperty
  a_startup: assert property (p_startup) else $error("start-up fetch mistimed");

  property p_nmi_arm;
    @(posedge clk) disable iff (srst) $rose(q.nmi_pend) |-> $past(q.arm_cnt) == NMI_ARM_CLOCKS;
  endproperty
  a_nmi_arm: assert property (p_nmi_arm) else $error("nmi accepted before arming");

  property p_nmi_first;
    @(posedge clk) disable iff (srst)
      (q.st == ST_RUN && boundary && q.nmi_pend && !grant_now)
      |=> (service_start && vector_addr == {NMI_TYPE, VEC_ENTRY_LSB} && irq_ack_strobe_n);
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("nmi not serviced first");

  property p_flags_push;
    @(posedge clk) disable iff (srst) flags_push |-> !if_flag;
  endproperty
  a_flags_push: assert property (p_flags_push) else $error("enable not cleared on response");

  property p_ack_pair;
    @(posedge clk) disable iff (srst)
      ($fell(irq_ack_strobe_n) && !q.ack_second) |-> ##4 $fell(irq_ack_strobe_n) ##3 service_start;
  endproperty
  a_ack_pair: assert property (p_ack_pair) else $error("acknowledge pair mistimed");

  property p_ack_nohold;
    @(posedge clk) disable iff (srst) (q.st == ST_ACK) |-> !hold_grant;
  endproperty
  a_ack_nohold: assert property (p_ack_nohold) else $error("hold granted during ack");

  property p_ack_lock;
    @(posedge clk) disable iff (srst)
      ($fell(irq_ack_strobe_n) && !q.ack_second && max_mode && !q.pfx_lock)
      |-> !lock_n [*4] ##1 lock_n;
  endproperty
  a_ack_lock: assert property (p_ack_lock) else $error("acknowledge lock window wrong");

  property p_halt_ale;
    @(posedge clk) disable iff (srst) ($rose(halted) && !max_mode) |-> !ale ##1 ale;
  endproperty
  a_halt_ale: assert property (p_halt_ale) else $error("halt latch strobe not delayed");

  property p_halt_exit;
    @(posedge clk) disable iff (srst) $fell(halted) |-> $past(q.nmi_pend || irq_ok);
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt left without interrupt");

  property p_lock_pfx;
    @(posedge clk) disable iff (srst) lock_prefix |=> !lock_n;
  endproperty
  a_lock_pfx: assert property (p_lock_pfx) else $error("lock not driven after prefix");

endmodule // cir_ctrl

`default_nettype wire

// [verif/cir_irq_model.sv]
/*
  Model of the interrupt controller and the non-maskable source at the block's pins.
  Assumes the bench pulses the commands for one clock and shares the processor clock.
*/
`default_nettype none

module cir_irq_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_nmi,
  input wire logic cmd_maskable_irq_req,
  input wire logic [7:0] type_val,
  input wire logic irq_ack_strobe_n,
  output logic nmi_pin,
  output logic maskable_irq_req,
  output logic [7:0] type_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] nmi_left;
  logic strobe_last;
  logic second;

  // The request drops only once the first strobe has fallen, as a real controller may.
  always_ff @(posedge clk) begin
    if (srst) begin
      nmi_left <= 3'h0;
      maskable_irq_req <= 1'b0;
      strobe_last <= 1'b1;
      second <= 1'b0;
    end else begin
      if (cmd_nmi)
        nmi_left <= 3'h4;
      else if (nmi_left != 3'h0)
        nmi_left <= nmi_left - 3'h1;
      if (cmd_maskable_irq_req)
        maskable_irq_req <= 1'b1;
      else if (!irq_ack_strobe_n)
        maskable_irq_req <= 1'b0;
      if (!strobe_last && irq_ack_strobe_n)
        second <= ~second;
      strobe_last <= irq_ack_strobe_n;
    end
  end

  // A clean pulse of four clocks, longer than two, with no bounce.
  assign nmi_pin = (nmi_left != 3'h0);
  // The type is driven from the second strobe's fall until one clock after it rises.
  // The block takes it at the end of its fourth bus state.
  // Outside that span the bus is released, so it shows the inverse value.
  assign type_byte = (second && (!irq_ack_strobe_n || !strobe_last)) ? type_val : ~type_val;

endmodule // cir_irq_model

`default_nettype wire

// [verif/tb_top.sv]
/*
  Self-checking bench for the interrupt and reset control block.
  Assumes the interrupt source model and the block share one 200 MHz clock.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cir_pkg::*;

  // Stimulus, all given a value at time zero.
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b0;
  logic test_n = 1'b1;
  logic hold_req = 1'b0;
  logic queue_full = 1'b0;
  logic io_write = 1'b0;
  logic io_direct = 1'b0;
  logic [7:0] type_val = 8'h00;
  logic [10:0] pu = 11'h000;
  logic nmi_pin, irq_req, core_run, fetch_start, ale, strobe_n, lock_n, io_mem, xdir, ss0;
  logic service_start, flags_push, if_flag, hold_grant, halted, wait_done, bus_quiet;
  logic [7:0] type_byte;
  logic [19:0] addr;
  logic [2:0] cycle_status;
  logic [VEC_W-1:0] vector_addr;
  wire logic [8:0] ev;
  int bad_count = 0;
  int n_compared = 0;
  int w;
  int m;

  // Events that the bounded waits look for.
  assign ev = {~strobe_n, ~hold_grant, ale, service_start, fetch_start, halted, hold_grant,
               ~lock_n, wait_done};

  always #2.5 clk = ~clk;

  cir_ctrl u_dut (
    .clk(clk), .srst(srst), .max_mode_strap(strap), .nmi_pin(nmi_pin),
    .maskable_irq_req(irq_req), .test_n(test_n), .hold_req(hold_req), .instr_end(pu[0]),
    .halt_exec(pu[1]), .lock_prefix(pu[2]), .lock_end(pu[3]), .wait_exec(pu[4]),
    .queue_full(queue_full), .if_set(pu[5]), .if_clear(pu[9]), .flags_restore(pu[10]),
    .restored_if(1'b1), .io_req(pu[6]), .io_write(io_write), .io_direct(io_direct),
    .io_port(8'hA5), .io_pointer_reg(16'hBEEF), .type_byte(type_byte),
    .core_run(core_run), .fetch_start(fetch_start), .addr(addr), .ale(ale),
    .irq_ack_strobe_n(strobe_n), .lock_n(lock_n), .cycle_status(cycle_status),
    .io_mem(io_mem), .xfer_direction(xdir), .status_zero_min(ss0),
    .service_start(service_start), .vector_addr(vector_addr), .flags_push(flags_push),
    .if_flag(if_flag), .hold_grant(hold_grant), .halted(halted), .wait_done(wait_done),
    .bus_quiet(bus_quiet)
  );

  cir_irq_model u_model (
    .clk(clk), .srst(srst), .cmd_nmi(pu[7]), .cmd_maskable_irq_req(pu[8]), .type_val(type_val),
    .irq_ack_strobe_n(strobe_n), .nmi_pin(nmi_pin), .maskable_irq_req(irq_req),
    .type_byte(type_byte)
  );

  // Shared helpers; a spare falling edge before each pulse keeps drivers from colliding.
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  task idle(input int k);
    repeat (k) @(negedge clk);
  endtask

  task pulse(input int k);
    @(negedge clk);
    pu[k] = 1'b1;
    @(negedge clk);
    pu[k] = 1'b0;
  endtask

  task automatic wait_hi(input int k, input string nm, output int n);
    for (n = 0; n < 40 && ev[k] !== 1'b1; n++) @(negedge clk);
    if (n == 40) begin
      $display("MISMATCH %s expected 1 seen timeout", nm);
      bad_count++;
      complete_run();
    end
  endtask

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Outputs held quiet in reset, then a counted start-up before the first fetch.
  task t_reset;
    chk("strobe in reset", 1'b1, strobe_n);
    chk("lock in reset", 1'b1, lock_n);
    chk("status in reset", CS_PASSIVE, cycle_status);
    chk("run in reset", 1'b0, core_run);
    srst = 1'b0;
    wait_hi(4, "fetch", w);
    // One clock leaves the reset state, then the start-up count runs its full length.
    chk("start-up clocks", 20'(INIT_CLOCKS) + 20'h1, 20'(w));
    chk("reset address", RESET_VECTOR, addr);
    chk("fetch status", CS_FETCH, cycle_status);
    idle(2);
    chk("core run", 1'b1, core_run);
    $display("test reset done");
  endtask

  // Port and pointer differ, so picking the wrong source shows in the address.
  task t_io;
    io_direct = 1'b1;
    pulse(6);
    wait_hi(6, "io ale", w);
    chk("direct addr", {IO_UPPER_ZERO, IO_PAGE_ZERO, 8'hA5}, addr);
    chk("read status", CS_IOR, cycle_status);
    chk("io select", 1'b1, io_mem);
    io_direct = 1'b0;
    io_write = 1'b1;
    pulse(6);
    wait_hi(6, "io ale", w);
    chk("pointer addr", {IO_UPPER_ZERO, 16'hBEEF}, addr);
    chk("write status", CS_IOW, cycle_status);
    $display("test io done");
  endtask

  // Both requests pending at once; the edge must win, then mask the level.
  task t_nmi;
    pulse(5);
    pulse(8);
    pulse(7);
    idle(8);
    pulse(0);
    wait_hi(5, "nmi service", w);
    chk("nmi vector", {NMI_TYPE, VEC_ENTRY_LSB}, vector_addr);
    chk("nmi no ack", 1'b1, strobe_n);
    chk("nmi flags push", 1'b1, flags_push);
    chk("if after nmi", 1'b0, if_flag);
    pulse(0);
    repeat (20) begin
      @(negedge clk);
      chk("masked maskable_irq_req", 1'b0, service_start);
    end
    pulse(7);
    idle(8);
    pulse(0);
    wait_hi(5, "second nmi", w);
    chk("second vector", {NMI_TYPE, VEC_ENTRY_LSB}, vector_addr);
    $display("test nmi done");
  endtask

  // A hold raised inside the acknowledge pair must wait until the pair is over.
  task t_maskable_irq_req;
    type_val = 8'hFF;
    pulse(5);
    pulse(0);
    wait_hi(8, "ack strobe", w);
    hold_req = 1'b1;
    for (w = 0; w < 12 && service_start !== 1'b1; w++) begin
      chk("grant in ack", 1'b0, hold_grant);
      @(negedge clk);
    end
    wait_hi(5, "maskable_irq_req service", w);
    chk("maskable_irq_req vector", {8'hFF, VEC_ENTRY_LSB}, vector_addr);
    chk("if after maskable_irq_req", 1'b0, if_flag);
    wait_hi(2, "grant after ack", w);
    hold_req = 1'b0;
    wait_hi(7, "grant drop", w);
    // Maximum mode: the lock spans the first strobe and ends at the second.
    strap = 1'b1;
    type_val = 8'h5A;
    pulse(5);
    pulse(8);
    idle(6);
    pulse(0);
    wait_hi(1, "ack lock", w);
    chk("strobe at lock", 1'b0, strobe_n);
    idle(2);
    chk("lock across pair", 1'b0, lock_n);
    wait_hi(5, "max maskable_irq_req service", w);
    chk("max vector", {8'h5A, VEC_ENTRY_LSB}, vector_addr);
    chk("lock after ack", 1'b1, lock_n);
    $display("test maskable_irq_req done");
  endtask

  // Halt in both modes; a plain boundary must not end it, an interrupt must.
  task t_halt;
    for (m = 0; m < 2; m++) begin
      strap = m[0];
      idle(6);
      pulse(1);
      wait_hi(3, "halted", w);
      if (m == 1) begin
        chk("max halt status", CS_HALT, cycle_status);
      end else begin
        chk("min halt status", {HALT_IO_MEM, HALT_DIR, HALT_SS0}, {io_mem, xdir, ss0});
        chk("ale on entry", 1'b0, ale);
        idle(1);
        chk("late ale", 1'b1, ale);
        hold_req = 1'b1;
        wait_hi(2, "halt grant", w);
        chk("halt in hold", 1'b1, halted);
        hold_req = 1'b0;
        wait_hi(6, "halt reissue", w);
        chk("halt after hold", 1'b1, halted);
      end
      pulse(0);
      idle(2);
      chk("halt kept", 1'b1, halted);
      pulse(7);
      wait_hi(5, "halt exit", w);
      idle(2);
      chk("halt left", 1'b0, halted);
    end
    strap = 1'b0;
    idle(6);
    $display("test halt done");
  endtask

  // A hold asked for under lock is recorded and granted only after the lock.
  task t_lock;
    pulse(2);
    wait_hi(1, "lock", w);
    chk("lock delay", 20'h0, w);
    hold_req = 1'b1;
    idle(8);
    chk("grant in lock", 1'b0, hold_grant);
    hold_req = 1'b0;
    idle(6);
    pulse(3);
    wait_hi(2, "recorded grant", w);
    chk("lock released", 1'b1, lock_n);
    wait_hi(7, "grant drop", w);
    $display("test lock done");
  endtask

  // Test wait with a full queue, a hold in the middle, then release by test low.
  task t_wait;
    queue_full = 1'b1;
    pulse(4);
    idle(2);
    chk("quiet in wait", 1'b1, bus_quiet);
    hold_req = 1'b1;
    wait_hi(2, "wait grant", w);
    hold_req = 1'b0;
    wait_hi(7, "wait grant drop", w);
    chk("still quiet", 1'b1, bus_quiet);
    test_n = 1'b0;
    wait_hi(0, "wait done", w);
    idle(1);
    chk("quiet after", 1'b0, bus_quiet);
    test_n = 1'b1;
    queue_full = 1'b0;
    pulse(10);
    chk("if restored", 1'b1, if_flag);
    pulse(9);
    chk("if cleared", 1'b0, if_flag);
    $display("test wait done");
  endtask

  // Reset is held past four clocks before the scenarios run.
  initial begin
    repeat (5) @(negedge clk);
    t_reset();
    t_io();
    t_nmi();
    t_maskable_irq_req();
    t_halt();
    t_lock();
    t_wait();
    complete_run();
  end

endmodule // tb_top

`default_nettype wire
